// ---- hw/axr_pkg.sv ----
// Purpose: shared constants, carriers and states of the axis home/limit/restore block
// Assumes: 100 MHz clock, four axes, 8-bit word-aligned register offsets
// Notes:   every offset, field position, non-zero reset value and timing count lives here
package axr_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SERVO_MIN_NS  = 48000;    // 48 us
  localparam int SERVO_MAX_NS  = 1966080;  // 1966.08 us
  // least period rounds up, longest rounds down
  localparam int SERVO_MIN_CYC = (SERVO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SERVO_MAX_CYC = SERVO_MAX_NS / CLK_PERIOD_NS;
  localparam int PERIOD_W      = 18;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SERVO_PERIOD = 8'h00;
  localparam logic [7:0] OFS_LIMIT_LEVEL  = 8'h04;
  localparam logic [7:0] OFS_INT_STATUS   = 8'h08;
  localparam logic [7:0] OFS_INT_MASK     = 8'h0C;
  localparam logic [7:0] OFS_HOME_TARGET  = 8'h10;
  localparam logic [7:0] OFS_HOME_CMD     = 8'h14;
  localparam logic [7:0] OFS_INDEX_SEL    = 8'h18;
  localparam logic [7:0] OFS_COORD_ACC    = 8'h1C;
  localparam logic [7:0] OFS_COORD_CTRL   = 8'h20;
  localparam logic [7:0] OFS_COORD_MAP    = 8'h24;
  localparam logic [7:0] OFS_AXIS_BASE    = 8'h40;
  localparam logic [7:0] OFS_AXIS_END     = 8'hBF;
  localparam int         AXIS_SPAN_LSB    = 5;    // 0x20 bytes per axis
  localparam logic [4:0] AX_MODE          = 5'h00;
  localparam logic [4:0] AX_INT_LIMIT     = 5'h04;
  localparam logic [4:0] AX_POSERR_LIMIT  = 5'h08;
  localparam logic [4:0] AX_OUT_LIMIT     = 5'h0C;
  localparam logic [4:0] AX_FILTER_GAIN   = 5'h10;
  localparam logic [4:0] AX_BREAK_VALUE   = 5'h14;
  localparam logic [4:0] AX_CAPTURE       = 5'h18;
  localparam logic [4:0] AX_POSITION      = 5'h1C;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int MODE_OPEN_BIT     = 0;
  localparam int MODE_AUTOSTOP_BIT = 7;
  localparam int MODE_AUTOUPD_BIT  = 10;
  localparam int MODE_PROF_LSB     = 11;
  localparam int MODE_PROF_MSB     = 13;
  localparam logic [2:0]  PROF_TCURVE    = 3'h0;
  localparam logic [15:0] MODE_RST       = 16'h0000;
  localparam logic [15:0] LIMIT_RST      = 16'h7FFF;
  localparam logic [15:0] COORD_ACC_RST  = 16'h4000;
  localparam int          CC_AUTOSTOP_BIT = 0;
  localparam int          CC_IMMED_BIT    = 1;
  localparam logic [1:0]  COORD_CTRL_RST = 2'h3;
  localparam logic [3:0]  COORD_MAP_RST  = 4'h0;
  localparam logic [7:0]  LIMIT_LEVEL_RST = 8'h00;
  localparam int          HOME_TGT_W     = 31;
  // events per axis inside the status word
  localparam int EV_PER_AXIS = 4;
  localparam int EV_LIM_POS  = 0;
  localparam int EV_LIM_NEG  = 1;
  localparam int EV_HOMED    = 2;
  localparam int EV_MISSED   = 3;

  // ----------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic home;
    logic index;
    logic lim_pos;
    logic lim_neg;
  } axr_pins_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } axr_bus_t;

  typedef enum {H_IDLE, H_BACKOFF, H_SEEK, H_INDEX} axr_home_t;

endpackage

// ---- hw/axr_axis_ctrl.sv ----
// Purpose: four-axis home search, limit level handling, hard restore and servo pacing
// Assumes: pins and hard_restore are asynchronous; host bus is on clk
// Notes:   one position count per servo period; status clears by writing ones
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

// Function
// RULE1: servo period programmable between 48 us and 1966.08 us.
// RULE2: hard restore accepted at any time and resets every control register.
// RULE3: restore zeroes motion and capture registers, status bits and interrupt masks.
// RULE4: restore zeroes filter parameters and breakpoint values of every axis.
// RULE5: restore sets T-curve, closed loop, no auto update, no auto stop.
// RULE6: restore sets integral, position error and output limits to 32767.
// RULE7: restore sets coordinate acceleration 16384, auto stop, immediate mode, no map.
// RULE8: home command moves toward target; without index stops where home triggers.
// RULE9: with index selected, keeps moving after home and stops at index trigger.
// RULE10: home already active: move away until it clears, then seek home.
// RULE11: home target accepted as signed value from -2^30 to 2^30-1.
// RULE12: host picks a target that lies beyond the home switch.
// RULE13: index select 0 means no index search, 1 means index search.
// RULE14: limit level bit 2n-2 positive, 2n-1 negative; 0 high, 1 low active.
// RULE15: host writes zeros into unused upper limit level bits.
// RULE16: after restore every limit input is active high.
// RULE17: wrong limit levels raise the positive and negative limit flags.
// RULE18: mode word: auto stop bit 7, auto update bit 10, profile bits 11-13.
module axr_axis_ctrl
  import axr_pkg::*;
#(
  parameter int SERVO_MIN = SERVO_MIN_CYC,
  parameter int SERVO_MAX = SERVO_MAX_CYC
) (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                hard_restore,
  input  wire axr_bus_t            bus_in,
  output logic        [31:0]       rdata_ff,
  input  wire axr_pins_t [3:0]     pin_in,
  output logic        [3:0]        step_ff,
  output logic        [3:0]        dir_ff,
  output logic                     irq_ff
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_axis(input logic [7:0] a);
    return (a >= OFS_AXIS_BASE) && (a <= OFS_AXIS_END);
  endfunction

  function automatic logic [1:0] axis_of(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFS_AXIS_BASE;
    return d[AXIS_SPAN_LSB+1:AXIS_SPAN_LSB];
  endfunction

  function automatic logic [PERIOD_W-1:0] clamp_period(input logic [PERIOD_W-1:0] v);
    if (v < PERIOD_W'(SERVO_MIN)) return PERIOD_W'(SERVO_MIN);
    if (v > PERIOD_W'(SERVO_MAX)) return PERIOD_W'(SERVO_MAX);
    return v;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // bit 16 is hard restore, bits 15:0 the axis pins
  logic [16:0]      sync1_ff;
  logic [16:0]      sync2_ff;
  logic [16:0]      sync3_ff;
  logic [16:0]      filt_ff;
  axr_pins_t [3:0]  fpin;
  logic             rst;

  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_ff <= 17'h00000;
      sync2_ff <= 17'h00000;
      sync3_ff <= 17'h00000;
      filt_ff  <= 17'h00000;
    end else begin
      sync1_ff <= {hard_restore, pin_in};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      // a bit moves only once the last two stages agree
      filt_ff  <= (filt_ff & (sync2_ff ^ sync3_ff)) | (sync3_ff & ~(sync2_ff ^ sync3_ff));
    end
  end

  assign fpin = filt_ff[15:0];
  // restore is a level: held as long as the host drives it
  assign rst  = srst | filt_ff[16];  // [RULE2]

  // ----------------------------------------------------------------
  // global control registers
  // ----------------------------------------------------------------
  logic [PERIOD_W-1:0]   period_ff;
  logic [7:0]            lvl_ff;
  logic [15:0]           mask_ff;
  logic [HOME_TGT_W-1:0] htgt_ff;
  logic [3:0]            idx_sel_ff;
  logic [15:0]           cacc_ff;
  logic [1:0]            cctrl_ff;
  logic [3:0]            cmap_ff;
  logic                  wr_g;

  assign wr_g = bus_in.wr && !is_axis(bus_in.addr);

  always_ff @(posedge clk) begin
    if (rst) begin
      period_ff  <= PERIOD_W'(SERVO_MIN);
      lvl_ff     <= LIMIT_LEVEL_RST;   // [RULE16]
      mask_ff    <= 16'h0000;          // [RULE3]
      htgt_ff    <= '0;                // [RULE3]
      idx_sel_ff <= 4'h0;              // [RULE13]
      cacc_ff    <= COORD_ACC_RST;     // [RULE7]
      cctrl_ff   <= COORD_CTRL_RST;    // [RULE7]
      cmap_ff    <= COORD_MAP_RST;     // [RULE7]
    end else if (wr_g) begin
      case (bus_in.addr)
        OFS_SERVO_PERIOD: period_ff  <= clamp_period(bus_in.wdata[PERIOD_W-1:0]);  // [RULE1]
        OFS_LIMIT_LEVEL:  lvl_ff     <= bus_in.wdata[7:0];                         // [RULE14]
        OFS_INT_MASK:     mask_ff    <= bus_in.wdata[15:0];
        OFS_HOME_TARGET:  htgt_ff    <= bus_in.wdata[HOME_TGT_W-1:0];              // [RULE11]
        OFS_INDEX_SEL:    idx_sel_ff <= bus_in.wdata[3:0];                         // [RULE13]
        OFS_COORD_ACC:    cacc_ff    <= bus_in.wdata[15:0];
        OFS_COORD_CTRL:   cctrl_ff   <= bus_in.wdata[1:0];
        OFS_COORD_MAP:    cmap_ff    <= bus_in.wdata[3:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // per-axis parameter registers
  // ----------------------------------------------------------------
  logic [15:0] mode_ff [4];
  logic [15:0] ilim_ff [4];
  logic [15:0] perr_ff [4];
  logic [15:0] olim_ff [4];
  logic [15:0] gain_ff [4];
  logic [31:0] brk_ff  [4];
  logic [1:0]  wax;
  logic [4:0]  wreg;

  assign wax  = axis_of(bus_in.addr);
  assign wreg = bus_in.addr[4:0];

  always_ff @(posedge clk) begin
    for (int a = 0; a < 4; a++) begin
      if (rst) begin
        mode_ff[a] <= MODE_RST;   // [RULE5]
        ilim_ff[a] <= LIMIT_RST;  // [RULE6]
        perr_ff[a] <= LIMIT_RST;  // [RULE6]
        olim_ff[a] <= LIMIT_RST;  // [RULE6]
        gain_ff[a] <= 16'h0000;   // [RULE4]
        brk_ff[a]  <= 32'h00000000;  // [RULE4]
      end else if (bus_in.wr && is_axis(bus_in.addr) && wax == 2'(a)) begin
        case (wreg)
          AX_MODE:         mode_ff[a] <= bus_in.wdata[15:0];  // [RULE18]
          AX_INT_LIMIT:    ilim_ff[a] <= bus_in.wdata[15:0];
          AX_POSERR_LIMIT: perr_ff[a] <= bus_in.wdata[15:0];
          AX_OUT_LIMIT:    olim_ff[a] <= bus_in.wdata[15:0];
          AX_FILTER_GAIN:  gain_ff[a] <= bus_in.wdata[15:0];
          AX_BREAK_VALUE:  brk_ff[a]  <= bus_in.wdata;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // servo period tick
  // ----------------------------------------------------------------
  logic [PERIOD_W-1:0] tcnt_ff;
  logic                tick_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      tcnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (tcnt_ff >= period_ff - PERIOD_W'(1)) begin
      tcnt_ff <= '0;
      tick_ff <= 1'b1;  // [RULE1]
    end else begin
      tcnt_ff <= tcnt_ff + PERIOD_W'(1);
      tick_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // home search engines
  // ----------------------------------------------------------------
  axr_home_t          st_ff  [4];
  logic signed [31:0] pos_ff [4];
  logic signed [31:0] tgt_ff [4];
  logic [31:0]        cap_ff [4];
  logic [3:0]         homed_ff;
  logic [3:0]         missed_ff;
  logic               start;
  logic [3:0]         toward;

  assign start = wr_g && bus_in.addr == OFS_HOME_CMD;

  always_comb begin
    for (int a = 0; a < 4; a++) toward[a] = tgt_ff[a] > pos_ff[a];
  end

  always_ff @(posedge clk) begin
    for (int a = 0; a < 4; a++) begin
      if (rst) begin
        st_ff[a]     <= H_IDLE;
        pos_ff[a]    <= 32'sh00000000;  // [RULE3]
        tgt_ff[a]    <= 32'sh00000000;
        cap_ff[a]    <= 32'h00000000;   // [RULE3]
        step_ff[a]   <= 1'b0;
        dir_ff[a]    <= 1'b0;
        homed_ff[a]  <= 1'b0;
        missed_ff[a] <= 1'b0;
      end else begin
        step_ff[a]   <= 1'b0;
        homed_ff[a]  <= 1'b0;
        missed_ff[a] <= 1'b0;
        if (start && bus_in.wdata[1:0] == 2'(a)) begin
          // sign extension keeps the target inside the accepted range
          tgt_ff[a] <= {htgt_ff[HOME_TGT_W-1], htgt_ff};  // [RULE11]
          st_ff[a]  <= fpin[a].home ? H_BACKOFF : H_SEEK;  // [RULE8] [RULE10]
        end else if (tick_ff) begin
          case (st_ff[a])
            H_BACKOFF: begin
              if (!fpin[a].home) begin
                st_ff[a] <= H_SEEK;  // [RULE10]
              end else begin
                step_ff[a] <= 1'b1;
                dir_ff[a]  <= !toward[a];
                pos_ff[a]  <= toward[a] ? pos_ff[a] - 32'sd1 : pos_ff[a] + 32'sd1;  // [RULE10]
              end
            end
            H_SEEK, H_INDEX: begin
              if (st_ff[a] == H_SEEK && fpin[a].home && idx_sel_ff[a]) begin
                st_ff[a] <= H_INDEX;  // [RULE9]
                if (pos_ff[a] != tgt_ff[a]) begin
                  step_ff[a] <= 1'b1;
                  dir_ff[a]  <= toward[a];
                  pos_ff[a]  <= toward[a] ? pos_ff[a] + 32'sd1 : pos_ff[a] - 32'sd1;
                end
              end else if ((st_ff[a] == H_SEEK) ? fpin[a].home : fpin[a].index) begin
                st_ff[a]    <= H_IDLE;  // [RULE8] [RULE9]
                cap_ff[a]   <= pos_ff[a];
                homed_ff[a] <= 1'b1;
              end else if (pos_ff[a] == tgt_ff[a]) begin
                // target reached with no trigger: host placed it short
                st_ff[a]     <= H_IDLE;  // [RULE12]
                missed_ff[a] <= 1'b1;
              end else begin
                step_ff[a] <= 1'b1;
                dir_ff[a]  <= toward[a];
                pos_ff[a]  <= toward[a] ? pos_ff[a] + 32'sd1 : pos_ff[a] - 32'sd1;  // [RULE8]
              end
            end
            default: st_ff[a] <= H_IDLE;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // limit levels, event status and interrupt
  // ----------------------------------------------------------------
  logic [15:0] stat_ff;
  logic [15:0] ev_set;
  logic [15:0] ev_clr;
  logic [3:0]  lim_p;
  logic [3:0]  lim_n;

  always_comb begin
    ev_set = 16'h0000;
    for (int a = 0; a < 4; a++) begin
      // a level bit of 1 inverts the pin so low becomes active
      lim_p[a] = fpin[a].lim_pos ^ lvl_ff[2*a];    // [RULE14]
      lim_n[a] = fpin[a].lim_neg ^ lvl_ff[2*a+1];  // [RULE14]
      ev_set[a*EV_PER_AXIS+EV_LIM_POS] = lim_p[a];  // [RULE17]
      ev_set[a*EV_PER_AXIS+EV_LIM_NEG] = lim_n[a];  // [RULE17]
      ev_set[a*EV_PER_AXIS+EV_HOMED]   = homed_ff[a];
      ev_set[a*EV_PER_AXIS+EV_MISSED]  = missed_ff[a];
    end
  end

  assign ev_clr = (wr_g && bus_in.addr == OFS_INT_STATUS) ? bus_in.wdata[15:0] : 16'h0000;

  always_ff @(posedge clk) begin
    if (rst) begin
      stat_ff <= 16'h0000;  // [RULE3]
    end else begin
      // a set in the clearing cycle survives
      stat_ff <= (stat_ff & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) irq_ff <= 1'b0;
    else     irq_ff <= |(stat_ff & mask_ff);
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic [1:0]  rax;

  assign rax = axis_of(bus_in.addr);

  always_comb begin
    rd_val = 32'h00000000;
    if (is_axis(bus_in.addr)) begin
      case (bus_in.addr[4:0])
        AX_MODE:         rd_val = {16'h0000, mode_ff[rax]};
        AX_INT_LIMIT:    rd_val = {16'h0000, ilim_ff[rax]};
        AX_POSERR_LIMIT: rd_val = {16'h0000, perr_ff[rax]};
        AX_OUT_LIMIT:    rd_val = {16'h0000, olim_ff[rax]};
        AX_FILTER_GAIN:  rd_val = {16'h0000, gain_ff[rax]};
        AX_BREAK_VALUE:  rd_val = brk_ff[rax];
        AX_CAPTURE:      rd_val = cap_ff[rax];
        AX_POSITION:     rd_val = pos_ff[rax];
        default:         rd_val = 32'h00000000;
      endcase
    end else begin
      case (bus_in.addr)
        OFS_SERVO_PERIOD: rd_val = {14'h0000, period_ff};
        OFS_LIMIT_LEVEL:  rd_val = {24'h000000, lvl_ff};
        OFS_INT_STATUS:   rd_val = {16'h0000, stat_ff};
        OFS_INT_MASK:     rd_val = {16'h0000, mask_ff};
        OFS_HOME_TARGET:  rd_val = {htgt_ff[HOME_TGT_W-1], htgt_ff};
        OFS_HOME_CMD: begin
          for (int a = 0; a < 4; a++) rd_val[a] = st_ff[a] != H_IDLE;
        end
        OFS_INDEX_SEL:    rd_val = {28'h0000000, idx_sel_ff};
        OFS_COORD_ACC:    rd_val = {16'h0000, cacc_ff};
        OFS_COORD_CTRL:   rd_val = {30'h00000000, cctrl_ff};
        OFS_COORD_MAP:    rd_val = {28'h0000000, cmap_ff};
        default:          rd_val = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst)           rdata_ff <= 32'h00000000;
    else if (bus_in.rd) rdata_ff <= rd_val;
    else                rdata_ff <= 32'h00000000;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence home_hit_s;
    !rst && tick_ff && !start && st_ff[0] == H_SEEK && fpin[0].home;
  endsequence

  sequence index_hit_s;
    !rst && tick_ff && !start && st_ff[1] == H_SEEK && fpin[1].home;
  endsequence

  sequence backoff_step_s;
    !rst && tick_ff && !start && st_ff[0] == H_BACKOFF && fpin[0].home;
  endsequence

  restore_status_a: assert property (rst |=> stat_ff == 16'h0000 && mask_ff == 16'h0000 // [RULE3]
    && pos_ff[0] == 32'sh00000000 && cap_ff[0] == 32'h00000000)
    else $error("restore left status, mask or position set");
  restore_filter_a: assert property (rst |=> gain_ff[3] == 16'h0000 // [RULE4]
    && brk_ff[3] == 32'h00000000)
    else $error("restore left filter or breakpoint value");
  restore_mode_a: assert property (rst |=> mode_ff[1][MODE_PROF_MSB:MODE_PROF_LSB] == PROF_TCURVE // [RULE5]
    && !mode_ff[1][MODE_AUTOSTOP_BIT] && !mode_ff[1][MODE_AUTOUPD_BIT]
    && !mode_ff[1][MODE_OPEN_BIT])
    else $error("restore mode word wrong");
  restore_limits_a: assert property (rst |=> ilim_ff[2] == 16'h7FFF // [RULE6]
    && perr_ff[2] == 16'h7FFF && olim_ff[2] == 16'h7FFF)
    else $error("restore limits not 32767");
  restore_coord_a: assert property (rst |=> cacc_ff == 16'h4000 && cctrl_ff == 2'h3 // [RULE7]
    && cmap_ff == 4'h0)
    else $error("restore coordinate settings wrong");
  period_range_a: assert property (!rst |-> period_ff >= PERIOD_W'(SERVO_MIN) // [RULE1]
    && period_ff <= PERIOD_W'(SERVO_MAX))
    else $error("servo period out of range");
  home_stop_a: assert property (home_hit_s ##0 !idx_sel_ff[0] |=> // [RULE8]
    st_ff[0] == H_IDLE && cap_ff[0] == $past(pos_ff[0]) && homed_ff[0] && !step_ff[0])
    else $error("home seek did not stop at trigger");
  index_follow_a: assert property (index_hit_s ##0 idx_sel_ff[1] |=> // [RULE9]
    st_ff[1] == H_INDEX && !homed_ff[1])
    else $error("index search not entered after home");
  backoff_dir_a: assert property (backoff_step_s |=> step_ff[0] // [RULE10]
    && dir_ff[0] == !$past(toward[0]))
    else $error("backoff did not move away from target");
  limit_flag_a: assert property (!rst && lim_p[1] ##1 !rst |-> // [RULE17]
    stat_ff[EV_PER_AXIS+EV_LIM_POS])
    else $error("active limit did not raise its flag");

endmodule // axr_axis_ctrl

// ---- verification/axr_plant.sv ----
// Purpose: axis plant model: step/dir pulses move a position, pins follow it
// Assumes: home switch covers HOME_AT and up, index mark from HOME_AT+3 up
// Notes:   limit pins carry the raw levels the bench sets, polarity untouched
`timescale 1ns/1ps
module axr_plant
  import axr_pkg::*;
#(
  parameter int HOME_AT = 5
) (
  input  wire logic        clk,
  input  wire logic [3:0]  step,
  input  wire logic [3:0]  dir,
  input  wire logic [7:0]  lim_raw,
  output axr_pins_t [3:0]  pins
);
  int pos [4] = '{0, 0, 0, 0};
  always @(posedge clk) begin
    for (int a = 0; a < 4; a++)
      if (step[a] === 1'b1) pos[a] <= (dir[a] === 1'b1) ? pos[a] + 1 : pos[a] - 1;
  end
  // switches are wide regions, so a late stop shows as a wrong position
  always_comb begin
    for (int a = 0; a < 4; a++) begin
      pins[a].home    = (pos[a] >= HOME_AT);
      pins[a].index   = (pos[a] >= HOME_AT + 3);
      pins[a].lim_pos = lim_raw[2*a];
      pins[a].lim_neg = lim_raw[2*a+1];
    end
  end
endmodule // axr_plant

// ---- verification/testbench.sv ----
// Purpose: self-checking bench for the axis home, limit and restore block
// Assumes: servo period shortened to 8..64 cycles, plant home switch at 5
// Notes:   register bus driven one strobe per access with a gap cycle
`timescale 1ns/1ps
module testbench;
  import axr_pkg::*;
  logic            clk          = 1'b0;
  logic            srst         = 1'b1;
  logic            hard_restore = 1'b0;
  axr_bus_t        bus          = '0;
  logic [7:0]      lim_raw      = 8'h00;
  logic [31:0]     rdata_ff;
  axr_pins_t [3:0] pins;
  logic [3:0]      step_ff;
  logic [3:0]      dir_ff;
  logic            irq_ff;
  logic [31:0]     d;
  logic [31:0]     lvl;
  logic [31:0]     raw;
  logic            back_seen    = 1'b0;
  int              num_errors   = 0;
  int              n_checks     = 0;
  int              pv [3]       = '{2, 1000, 20};
  int              pe [3]       = '{8, 64, 20};

  always #5 clk = ~clk;
  always @(posedge clk) if (step_ff[0] === 1'b1 && dir_ff[0] === 1'b0) back_seen <= 1'b1;

  axr_axis_ctrl #(.SERVO_MIN(8), .SERVO_MAX(64)) uut (
    .clk(clk), .srst(srst), .hard_restore(hard_restore), .bus_in(bus),
    .rdata_ff(rdata_ff), .pin_in(pins), .step_ff(step_ff), .dir_ff(dir_ff),
    .irq_ff(irq_ff));
  axr_plant plant (.clk(clk), .step(step_ff), .dir(dir_ff), .lim_raw(lim_raw), .pins(pins));

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus.addr  <= a;
    bus.wdata <= v;
    bus.wr    <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // plain read: the word lands in d for the caller to judge
  task automatic rd_only(input logic [7:0] a);
    @(posedge clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata_ff;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd_only(a);
    chk($sformatf("reg %h", a), e, d);
  endtask
  function automatic logic [31:0] rst_val(input logic [7:0] a);
    if (a >= 8'h40)
      return (a[4:0] inside {5'h04, 5'h08, 5'h0C}) ? 32'h0000_7FFF : 32'h0;
    case (a)
      8'h00:   return 32'h8;
      8'h1C:   return 32'h4000;
      8'h20:   return 32'h3;
      default: return 32'h0;
    endcase
  endfunction
  function automatic logic [31:0] lim_exp(input logic [7:0] r, input logic [7:0] l);
    lim_exp = '0;
    for (int a = 0; a < 4; a++) begin
      lim_exp[4*a]   = r[2*a] ^ l[2*a];
      lim_exp[4*a+1] = r[2*a+1] ^ l[2*a+1];
    end
  endfunction
  // unmapped holes 0x28..0x3C ride along and must read zero
  task automatic chk_rst();
    for (int a = 0; a < 'hC0; a += 4)
      if (a != 'h10) rchk(a[7:0], rst_val(a[7:0]));
  endtask
  task automatic home_axis(input logic [31:0] ax);
    wr(8'h14, ax);
    for (int i = 0; i < 100; i++) begin
      rd_only(8'h14);
      if (d[3:0] === 4'h0) break;
    end
    chk("home busy", 32'h0, d);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'hE07B));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk_rst();
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, pv[i]);
      rchk(8'h00, pe[i]);
    end
    wr(8'h40, 32'h1480);
    rchk(8'h40, 32'h1480);
    wr(8'h10, 32'h4000_0000);
    rchk(8'h10, 32'hC000_0000);
    wr(8'h10, 32'h3FFF_FFFF);
    rchk(8'h10, 32'h3FFF_FFFF);
    for (int a = 0; a < 'hC0; a += 4)
      if (a != 'h08 && a != 'h14) wr(a[7:0], $urandom);
    hard_restore <= 1'b1;
    repeat (8) @(posedge clk);
    hard_restore <= 1'b0;
    repeat (8) @(posedge clk);
    chk_rst();
    for (int i = 0; i < 6; i++) begin
      lvl = (i == 0) ? 32'h0 : ($urandom & 32'hFF);
      raw = $urandom;
      wr(8'h04, lvl);
      lim_raw <= raw[7:0];
      repeat (8) @(posedge clk);
      wr(8'h08, 32'hFFFF);
      repeat (2) @(posedge clk);
      rd_only(8'h08);
      chk("limit flags", lim_exp(raw[7:0], lvl[7:0]), d & 32'h3333);
    end
    lim_raw <= 8'h00;
    wr(8'h04, 32'h0);
    repeat (8) @(posedge clk);
    wr(8'h08, 32'hFFFF);
    wr(8'h0C, 32'h0004);
    wr(8'h10, 32'd20);
    wr(8'h18, 32'h2);
    home_axis(32'h0);
    rchk(8'h5C, 32'd5);
    rchk(8'h58, 32'd5);
    chk("irq", 32'h1, {31'h0, irq_ff});
    wr(8'h08, 32'h4);
    repeat (2) @(posedge clk);
    #1 chk("irq", 32'h0, {31'h0, irq_ff});
    back_seen = 1'b0;
    home_axis(32'h0);
    chk("backoff", 32'h1, {31'h0, back_seen});
    rchk(8'h5C, 32'd5);
    home_axis(32'h1);
    rchk(8'h7C, 32'd8);
    rchk(8'h08, 32'h44);
    // target short of the home switch: axis stops there and flags a miss
    wr(8'h10, 32'd3);
    home_axis(32'h2);
    rchk(8'h9C, 32'd3);
    rchk(8'h08, 32'h844);
    wr(8'h0C, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk("irq", 32'h0, {31'h0, irq_ff});
    end_of_test();
  end
endmodule // testbench
